// ==== design/stm_defs.svh ====
// Register offsets, field positions, reset values and timing counts of the
// symbol-table modulator. Included by the modulator, the symbol RAM and the testbench top.
`ifndef STM_DEFS_SVH
`define STM_DEFS_SVH

`define STM_CLK_HZ        20000000
`define STM_SYM_RATE_MAX  1000000
`define STM_SYM_RATE_MIN  1
`define STM_SYM_PER_MIN   ((`STM_CLK_HZ + `STM_SYM_RATE_MAX - 1) / `STM_SYM_RATE_MAX)
`define STM_SYM_PER_MAX   (`STM_CLK_HZ / `STM_SYM_RATE_MIN)
`define STM_CW_MIN_HZ     10
`define STM_CW_MAX_HZ     50000000
`define STM_CW_RST_HZ     1000000
`define STM_CW_INC_K      (((64'h1 << 48) + (`STM_CLK_HZ / 2)) / `STM_CLK_HZ)

`define STM_TAB_DEPTH     256
`define STM_OFS_CTRL      5'h00
`define STM_OFS_PERIOD    5'h04
`define STM_OFS_MARKER    5'h08
`define STM_OFS_DATA      5'h0c
`define STM_OFS_STATUS    5'h10
`define STM_OFS_CWFREQ    8'h40

`define STM_CTRL_MODE     1:0
`define STM_CTRL_TYPE     4:2
`define STM_CTRL_GATE     5
`define STM_CTRL_CLEAR    8
`define STM_ENT_SYM       7:0
`define STM_ENT_A         19:8
`define STM_ENT_B         31:20

`endif

// ==== design/stm_modulator.sv ====
// Two symbol-table PSK/QAM modulators with a shared sine carrier, APB slave.
// Assumes an APB master on clk and a DAC stage that takes 12-bit samples.
//
// Function
// - Six standard phase keying types chosen by the type field.
// - Phase symbol table starts empty; software loads it before output appears.
// - Carrier gate bit passes the carrier or gives bare I/Q baseband.
// - Modulation carrier is always sine, frequency settable from 10 Hz to 50 MHz.
// - Symbols step at a programmable rate, 1 to one million per second.
// - Sync pulse when stepping reaches the marker index inside the list.
// - Custom phase mode takes a 12-bit phase per symbol, resolved to 64 steps, rest as standard.
// - 16, 64, 256 point QAM plus custom constellation by type field.
// - QAM symbol table starts empty; software loads it before output appears.
// - Custom QAM mode takes any I/Q per symbol, rest as standard.
// - Two independent modulators, each driving its own output pair.
// - Modulation off gives continuous plain sine carrier at shared frequency.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "stm_defs.svh"

module stm_modulator #(
	parameter logic [24:0] SYM_PERIOD_MAX = 25'(`STM_SYM_PER_MAX)
) (
	input  wire logic                         clk,
	input  wire logic                         reset_n,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [7:0]                   paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	output stm_pkg::stm_pair_s [1:0]          pair_out,
	output logic      [1:0]                   sync_out
);
	localparam stm_pkg::stm_mod_s MOD_RST = '{
		mode: stm_pkg::STM_MODE_OFF, typ: 3'h0, gate: 1'b1,
		period: 25'(`STM_SYM_PER_MIN), marker: 8'h00, len: 9'h000, idx: 8'h00,
		div: 25'h0, rd_pend: 1'b0, sym_valid: 1'b0, dacc: 12'h000,
		i: 12'sh000, q: 12'sh000, q_next: 12'sh000, sync: 1'b0, out: 24'h0
	};
	localparam stm_pkg::stm_state_s ST_RST = '{
		m: {MOD_RST, MOD_RST}, cw: 26'(`STM_CW_RST_HZ), incr: 32'h0,
		ph: 32'h0, prdata: 32'h0, pslverr: 1'b0
	};

	stm_pkg::stm_state_s st_q;
	stm_pkg::stm_state_s st_d;
	logic [1:0]          tick;
	logic [1:0]          wr_en;
	logic [7:0]          rd_addr [1:0];
	logic [31:0]         rd_data [1:0];
	stm_pkg::stm_samp_t  car_cos;
	stm_pkg::stm_samp_t  car_sin;

	function automatic stm_pkg::stm_samp_t quarter(input logic [4:0] k);
		case (k)
			5'h00: return 12'sh000;
			5'h01: return 12'sh0c9;
			5'h02: return 12'sh18f;
			5'h03: return 12'sh252;
			5'h04: return 12'sh30f;
			5'h05: return 12'sh3c5;
			5'h06: return 12'sh471;
			5'h07: return 12'sh513;
			5'h08: return 12'sh5a7;
			5'h09: return 12'sh62e;
			5'h0a: return 12'sh6a6;
			5'h0b: return 12'sh70d;
			5'h0c: return 12'sh763;
			5'h0d: return 12'sh7a7;
			5'h0e: return 12'sh7d8;
			5'h0f: return 12'sh7f5;
			default: return 12'sh7ff;
		endcase
	endfunction

	// 64 steps per turn; finer phase bits are dropped to keep the table small
	function automatic stm_pkg::stm_samp_t sin6(input logic [5:0] p);
		logic [4:0] k;
		k = p[4] ? 5'(5'h10 - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
		return p[5] ? -quarter(k) : quarter(k);
	endfunction

	function automatic stm_pkg::stm_samp_t cos6(input logic [5:0] p);
		return sin6(6'(p + 6'h10));
	endfunction

	// Evenly spaced levels, odd multiples of a step, centred on zero
	function automatic stm_pkg::stm_samp_t qam_lvl(input logic [3:0] v, input logic [1:0] sel);
		logic signed [5:0] c;
		c = 6'sh00;
		case (sel)
			2'h0: return stm_pkg::stm_samp_t'($signed({3'h0, v[1:0], 1'b1}) - 6'sh04) <<< 9;
			2'h1: return stm_pkg::stm_samp_t'($signed({2'h0, v[2:0], 1'b1}) - 6'sh08) <<< 8;
			default: begin
				c = $signed({1'b0, v, 1'b1}) - 6'sh10;
				return stm_pkg::stm_samp_t'(c) <<< 7;
			end
		endcase
	endfunction

	// Mixing a full-scale QAM corner can exceed full scale, so clip
	function automatic stm_pkg::stm_samp_t sat(input logic signed [24:0] x);
		logic signed [13:0] s;
		s = x[24:11];
		if (s > 14'sh07ff) begin
			return 12'sh7ff;
		end else if (s < -14'sh0800) begin
			return -12'sh800;
		end
		return s[11:0];
	endfunction

	assign car_cos = cos6(st_q.ph[31:26]);
	assign car_sin = sin6(st_q.ph[31:26]);

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_mod
			stm_symbol_ram u_ram (
				.clk     (clk),
				.wr_en   (wr_en[g]),
				.wr_addr (st_q.m[g].len[7:0]),
				.wr_data (pwdata),
				.rd_addr (rd_addr[g]),
				.rd_data (rd_data[g])
			);
			assign pair_out[g] = st_q.m[g].out;
			assign sync_out[g] = st_q.m[g].sync;
		end
	endgenerate

	always_comb begin
		stm_pkg::stm_mod_s m;
		logic [31:0]        rd;
		logic [11:0]        ph12;
		logic [49:0]        prod;
		logic               wr_acc;
		logic signed [23:0] p_ic;
		logic signed [23:0] p_qs;
		logic signed [23:0] p_is;
		logic signed [23:0] p_qc;
		m      = MOD_RST;
		rd     = 32'h0;
		ph12   = 12'h000;
		p_ic   = 24'sh0;
		p_qs   = 24'sh0;
		p_is   = 24'sh0;
		p_qc   = 24'sh0;
		st_d   = st_q;
		tick   = 2'h0;
		wr_en  = 2'h0;
		wr_acc = psel && penable && pwrite;
		// Wraps above 20 MHz: outputs alias at the clock's sample rate
		prod    = 50'(st_q.cw) * 50'(`STM_CW_INC_K);
		st_d.incr = prod[47:16];
		st_d.ph   = st_q.ph + st_q.incr;
		for (int k = 0; k < 2; k++) begin
			m      = st_q.m[k];
			rd     = rd_data[k];
			m.sync = 1'b0;
			if (m.mode == stm_pkg::STM_MODE_OFF || m.len == 9'h000) begin
				m.div       = 25'h0;
				m.idx       = 8'h00;
				m.sym_valid = 1'b0;
				m.rd_pend   = 1'b0;
				m.dacc      = 12'h000;
				m.i         = 12'sh000;
				m.q         = 12'sh000;
			end else begin
				// Greater-or-equal so a shortened period cannot be overrun
				tick[k] = m.sym_valid && (m.div >= m.period - 25'h1);
				if (tick[k]) begin
					m.div = 25'h0;
					m.idx = (9'(m.idx) == m.len - 9'h1) ? 8'h00 : m.idx + 8'h1;
				end else if (m.sym_valid) begin
					m.div = m.div + 25'h1;
				end
				m.rd_pend = tick[k] || (!m.sym_valid && !st_q.m[k].rd_pend);
				if (m.mode == stm_pkg::STM_MODE_PSK && m.typ == stm_pkg::STM_PSK_OQUAD &&
				    st_q.m[k].div == (st_q.m[k].period >> 1)) begin
					m.q = m.q_next;
				end
				if (st_q.m[k].rd_pend) begin
					m.sym_valid = 1'b1;
					m.sync      = (m.idx == m.marker);
					if (m.mode == stm_pkg::STM_MODE_PSK) begin
						case (stm_pkg::stm_psk_e'(m.typ))
							stm_pkg::STM_PSK_BIN: ph12 = {rd[0], 11'h000};
							stm_pkg::STM_PSK_QUAD,
							stm_pkg::STM_PSK_OQUAD: ph12 = {rd[1:0], 10'h000} + 12'h200;
							stm_pkg::STM_PSK_DQUAD: begin
								ph12   = m.dacc + {rd[1:0], 10'h000} + 12'h200;
								m.dacc = ph12;
							end
							stm_pkg::STM_PSK_8: ph12 = {rd[2:0], 9'h000};
							stm_pkg::STM_PSK_16: ph12 = {rd[3:0], 8'h00};
							stm_pkg::STM_PSK_CUSTOM: ph12 = rd[`STM_ENT_A];
							default: ph12 = 12'h000;
						endcase
						m.i = cos6(ph12[11:6]);
						if (m.typ == stm_pkg::STM_PSK_OQUAD) begin
							m.q_next = sin6(ph12[11:6]);
						end else begin
							m.q = sin6(ph12[11:6]);
						end
					end else begin
						case (stm_pkg::stm_qam_e'(m.typ[1:0]))
							stm_pkg::STM_QAM_16: begin
								m.i = qam_lvl({2'h0, rd[3:2]}, 2'h0);
								m.q = qam_lvl({2'h0, rd[1:0]}, 2'h0);
							end
							stm_pkg::STM_QAM_64: begin
								m.i = qam_lvl({1'b0, rd[5:3]}, 2'h1);
								m.q = qam_lvl({1'b0, rd[2:0]}, 2'h1);
							end
							stm_pkg::STM_QAM_256: begin
								m.i = qam_lvl(rd[7:4], 2'h2);
								m.q = qam_lvl(rd[3:0], 2'h2);
							end
							default: begin
								m.i = rd[`STM_ENT_A];
								m.q = rd[`STM_ENT_B];
							end
						endcase
					end
				end
			end
			p_ic = st_q.m[k].i * car_cos;
			p_qs = st_q.m[k].q * car_sin;
			p_is = st_q.m[k].i * car_sin;
			p_qc = st_q.m[k].q * car_cos;
			if (st_q.m[k].mode == stm_pkg::STM_MODE_OFF) begin
				m.out.a = car_cos;
				m.out.b = car_sin;
			end else if (!st_q.m[k].sym_valid) begin
				m.out = 24'h0;
			end else if (st_q.m[k].gate) begin
				m.out.a = sat(25'(p_ic) - 25'(p_qs));
				m.out.b = sat(25'(p_is) + 25'(p_qc));
			end else begin
				m.out.a = st_q.m[k].i;
				m.out.b = st_q.m[k].q;
			end
			// Register writes come last so a clear overrides stepping
			if (wr_acc && paddr[7:6] == 2'h0 && paddr[5] == 1'(k)) begin
				case (paddr[4:0])
					`STM_OFS_CTRL: begin
						m.mode = (pwdata[`STM_CTRL_MODE] == 2'h3) ? stm_pkg::STM_MODE_OFF
							: stm_pkg::stm_mode_e'(pwdata[`STM_CTRL_MODE]);
						m.typ  = pwdata[`STM_CTRL_TYPE];
						m.gate = pwdata[`STM_CTRL_GATE];
						if (pwdata[`STM_CTRL_CLEAR]) begin
							m.len       = 9'h000;
							m.idx       = 8'h00;
							m.div       = 25'h0;
							m.marker    = 8'h00;
							m.sym_valid = 1'b0;
							m.rd_pend   = 1'b0;
							m.sync      = 1'b0;
						end
					end
					`STM_OFS_PERIOD: begin
						if (pwdata < 32'(`STM_SYM_PER_MIN)) begin
							m.period = 25'(`STM_SYM_PER_MIN);
						end else if (pwdata > 32'(SYM_PERIOD_MAX)) begin
							m.period = SYM_PERIOD_MAX;
						end else begin
							m.period = pwdata[24:0];
						end
					end
					`STM_OFS_MARKER: begin
						if (m.len == 9'h000) begin
							m.marker = 8'h00;
						end else if (pwdata >= 32'(m.len)) begin
							m.marker = 8'(m.len - 9'h1);
						end else begin
							m.marker = pwdata[7:0];
						end
					end
					`STM_OFS_DATA: begin
						if (m.len < 9'(`STM_TAB_DEPTH)) begin
							wr_en[k] = 1'b1;
							m.len    = m.len + 9'h1;
						end
					end
					default: m.len = m.len;
				endcase
			end
			rd_addr[k] = m.idx;
			st_d.m[k]  = m;
		end
		if (wr_acc && paddr == `STM_OFS_CWFREQ) begin
			if (pwdata < 32'(`STM_CW_MIN_HZ)) begin
				st_d.cw = 26'(`STM_CW_MIN_HZ);
			end else if (pwdata > 32'(`STM_CW_MAX_HZ)) begin
				st_d.cw = 26'(`STM_CW_MAX_HZ);
			end else begin
				st_d.cw = pwdata[25:0];
			end
		end
		// Read data and error are captured in the setup cycle
		st_d.prdata  = 32'h0;
		st_d.pslverr = 1'b0;
		if (psel && !penable) begin
			if (paddr[7:6] == 2'h0) begin
				case (paddr[4:0])
					`STM_OFS_CTRL: st_d.prdata = {23'h0, 1'b0, 2'h0,
						st_q.m[paddr[5]].gate, st_q.m[paddr[5]].typ, st_q.m[paddr[5]].mode};
					`STM_OFS_PERIOD: st_d.prdata = {7'h0, st_q.m[paddr[5]].period};
					`STM_OFS_MARKER: st_d.prdata = {24'h0, st_q.m[paddr[5]].marker};
					`STM_OFS_DATA: st_d.prdata = 32'h0;
					`STM_OFS_STATUS: st_d.prdata = {7'h0, st_q.m[paddr[5]].sym_valid,
						st_q.m[paddr[5]].idx, 7'h0, st_q.m[paddr[5]].len};
					default: st_d.pslverr = 1'b1;
				endcase
			end else if (paddr == `STM_OFS_CWFREQ) begin
				st_d.prdata = {6'h0, st_q.cw};
			end else begin
				st_d.pslverr = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_q <= ST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign pready  = 1'b1;
	assign prdata  = st_q.prdata;
	assign pslverr = st_q.pslverr;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_load_psk(logic [2:0] t);
		st_q.m[0].rd_pend && st_q.m[0].mode == stm_pkg::STM_MODE_PSK && st_q.m[0].typ == t;
	endsequence
	sequence s_load_qam(logic [1:0] t);
		st_q.m[0].rd_pend && st_q.m[0].mode == stm_pkg::STM_MODE_QAM && st_q.m[0].typ[1:0] == t;
	endsequence
	sequence s_empty;
		st_q.m[0].mode != stm_pkg::STM_MODE_OFF && st_q.m[0].len == 9'h000;
	endsequence
	sequence s_last_tick;
		tick[0] && (9'(st_q.m[0].idx) == st_q.m[0].len - 9'h1);
	endsequence

	AST_QPSK_FIRST_QUADRANT: assert property (
		s_load_psk(3'h1) ##0 (rd_data[0][1:0] == 2'h0) |=>
		st_q.m[0].i > 12'sh0 && st_q.m[0].q == st_q.m[0].i)
		else $error("QPSK symbol 00 did not land at 45 degrees");
	AST_EMPTY_QUIET: assert property (
		s_empty ##1 s_empty |=> pair_out[0] == 24'h0)
		else $error("Empty table produced output");
	AST_GATE_OFF_BASEBAND: assert property (
		st_q.m[0].mode != stm_pkg::STM_MODE_OFF && !st_q.m[0].gate && st_q.m[0].sym_valid
		|=> pair_out[0].a == $past(st_q.m[0].i))
		else $error("Suppressed carrier did not give baseband I");
	AST_CW_RANGE: assert property (
		st_q.cw >= 26'(`STM_CW_MIN_HZ) && st_q.cw <= 26'(`STM_CW_MAX_HZ))
		else $error("Carrier frequency outside its range");
	AST_SYMBOL_SPACING: assert property (
		tick[0] |=> (!tick[0]) [*8])
		else $error("Symbols stepped faster than the top rate");
	AST_SYNC_AT_MARKER: assert property (
		sync_out[0] |-> st_q.m[0].idx == st_q.m[0].marker && 9'(st_q.m[0].marker) < st_q.m[0].len)
		else $error("Sync pulse away from the marker");
	AST_CUSTOM_PHASE: assert property (
		s_load_psk(3'h6) ##0 (rd_data[0][`STM_ENT_A] == 12'h000) |=>
		st_q.m[0].i == 12'sh7ff && st_q.m[0].q == 12'sh000)
		else $error("Custom phase zero not mapped to +I");
	AST_QAM16_CORNER: assert property (
		s_load_qam(2'h0) ##0 (rd_data[0][3:0] == 4'h0) |=>
		st_q.m[0].i == -12'sh600 && st_q.m[0].q == -12'sh600)
		else $error("16QAM symbol 0 not at the corner");
	AST_CUSTOM_IQ: assert property (
		s_load_qam(2'h3) |=> st_q.m[0].i == $signed($past(rd_data[0][`STM_ENT_A])) &&
		st_q.m[0].q == $signed($past(rd_data[0][`STM_ENT_B])))
		else $error("Custom I/Q not taken from the entry");
	AST_OFF_CARRIER: assert property (
		reset_n && st_q.m[0].mode == stm_pkg::STM_MODE_OFF |=> pair_out[0].a == $past(car_cos))
		else $error("Modulation off did not give the carrier");
	AST_WRAP: assert property (
		s_last_tick |=> st_q.m[0].idx == 8'h00)
		else $error("Symbol index did not wrap after the last entry");
endmodule

// ==== design/stm_pkg.sv ====
// Types shared by the symbol-table modulator files.
// Assumes stm_defs.svh supplies the numeric constants.
package stm_pkg;
	typedef enum logic [1:0] {STM_MODE_OFF, STM_MODE_PSK, STM_MODE_QAM} stm_mode_e;
	typedef enum logic [2:0] {
		STM_PSK_BIN, STM_PSK_QUAD, STM_PSK_OQUAD, STM_PSK_DQUAD,
		STM_PSK_8, STM_PSK_16, STM_PSK_CUSTOM
	} stm_psk_e;
	typedef enum logic [1:0] {STM_QAM_16, STM_QAM_64, STM_QAM_256, STM_QAM_CUSTOM} stm_qam_e;

	typedef logic signed [11:0] stm_samp_t;

	typedef struct packed {
		stm_samp_t a;
		stm_samp_t b;
	} stm_pair_s;

	typedef struct packed {
		stm_mode_e   mode;
		logic [2:0]  typ;
		logic        gate;
		logic [24:0] period;
		logic [7:0]  marker;
		logic [8:0]  len;
		logic [7:0]  idx;
		logic [24:0] div;
		logic        rd_pend;
		logic        sym_valid;
		logic [11:0] dacc;
		stm_samp_t   i;
		stm_samp_t   q;
		stm_samp_t   q_next;
		logic        sync;
		stm_pair_s   out;
	} stm_mod_s;

	typedef struct packed {
		stm_mod_s [1:0] m;
		logic [25:0]    cw;
		logic [31:0]    incr;
		logic [31:0]    ph;
		logic [31:0]    prdata;
		logic           pslverr;
	} stm_state_s;
endpackage

// ==== design/stm_symbol_ram.sv ====
// Symbol table storage for one modulator: one write port, one read port.
// Read data is registered, so it appears one clock after the address.
`timescale 1ns/10ps
`include "stm_defs.svh"

module stm_symbol_ram (
	input  wire logic        clk,
	input  wire logic        wr_en,
	input  wire logic [7:0]  wr_addr,
	input  wire logic [31:0] wr_data,
	input  wire logic [7:0]  rd_addr,
	output logic      [31:0] rd_data
);
	logic [31:0] mem [0:`STM_TAB_DEPTH-1];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

// ==== testbench/stm_dac_stage.sv ====
// Stand-in for the output stage: holds the two sample pairs and counts sync pulses.
// Assumes samples and sync arrive as registered outputs on clk.
`timescale 1ns/10ps

module stm_dac_stage (
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	input  wire stm_pkg::stm_pair_s [1:0] pair_in,
	input  wire logic [1:0]               sync_in,
	output stm_pkg::stm_pair_s [1:0]      held_q,
	output logic [15:0]                   sync_cnt0,
	output logic [15:0]                   sync_cnt1
);
	// Each pair is taken on its own, like two separate converter channels
	always @(posedge clk) begin
		if (!reset_n) begin
			held_q <= '0;
			sync_cnt0 <= '0;
			sync_cnt1 <= '0;
		end else begin
			held_q <= pair_in;
			sync_cnt0 <= sync_cnt0 + 16'(sync_in[0]);
			sync_cnt1 <= sync_cnt1 + 16'(sync_in[1]);
		end
	end
endmodule

// ==== testbench/stm_modulator_tb_top.sv ====
// Self-checking bench for the two-channel symbol-table modulator.
// Assumes stm_defs.svh is on the include path and the stage model is compiled first.
`timescale 1ns/10ps
`include "stm_defs.svh"

module stm_modulator_tb_top;
	localparam int P = 20;
	logic                     clk = 1'b0;
	logic                     reset_n = 1'b0;
	logic                     psel = 1'b0;
	logic                     penable = 1'b0;
	logic                     pwrite = 1'b0;
	logic [7:0]               paddr = '0;
	logic [31:0]              pwdata = '0;
	logic [31:0]              prdata;
	logic                     pready;
	logic                     pslverr;
	stm_pkg::stm_pair_s [1:0] pair_out;
	logic [1:0]               sync_out;
	logic [15:0]              sync_cnt0;
	logic [15:0]              sync_cnt1;
	int                       n_mismatch = 0;
	int                       total_checks = 0;

	always #25 clk = ~clk;

	// Short period ceiling keeps the clamp test quick
	stm_modulator #(.SYM_PERIOD_MAX(25'd200)) DUT (.clk(clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pair_out(pair_out), .sync_out(sync_out));
	stm_dac_stage stage (.clk(clk), .reset_n(reset_n), .pair_in(pair_out), .sync_in(sync_out),
		.held_q(), .sync_cnt0(sync_cnt0), .sync_cnt1(sync_cnt1));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the slave's answer
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
		apb(1'b0, a, 32'h0, q, e);
	endtask

	function automatic logic [7:0] ra(input int k, input logic [7:0] o);
		return 8'(k * 32) + o;
	endfunction

	task automatic ctrl(input int k, input int md, input int ty, input int g);
		wr(ra(k, `STM_OFS_CTRL), 32'(md) | (32'(ty) << 2) | (32'(g) << 5));
	endtask

	task automatic smp(input int k, output stm_pkg::stm_samp_t a, output stm_pkg::stm_samp_t b);
		@(negedge clk);
		a = pair_out[k].a;
		b = pair_out[k].b;
	endtask

	task automatic t_reset();
		logic [31:0] q;
		logic e;
		stm_pkg::stm_samp_t a1, b1, a2, b2;
		rd(ra(0, `STM_OFS_STATUS), q, e);
		chk("len0 after reset", 32'h0, {23'h0, q[8:0]});
		rd(ra(1, `STM_OFS_STATUS), q, e);
		chk("len1 after reset", 32'h0, {23'h0, q[8:0]});
		rd(`STM_OFS_CWFREQ, q, e);
		chk("carrier reset", 32'd1000000, q);
		rd(8'h14, q, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		smp(1, a1, b1);
		smp(1, a2, b2);
		chk("carrier moves", 32'h1, {31'h0, {a1, b1} !== {a2, b2}});
		$display("test reset done");
	endtask

	task automatic t_clamp();
		logic [31:0] q;
		logic e;
		wr(ra(0, `STM_OFS_PERIOD), 32'd3);
		rd(ra(0, `STM_OFS_PERIOD), q, e);
		chk("period floor", 32'd20, q);
		wr(ra(0, `STM_OFS_PERIOD), 32'd1000);
		rd(ra(0, `STM_OFS_PERIOD), q, e);
		chk("period ceiling", 32'd200, q);
		wr(`STM_OFS_CWFREQ, 32'd5);
		rd(`STM_OFS_CWFREQ, q, e);
		chk("carrier floor", 32'd10, q);
		wr(`STM_OFS_CWFREQ, 32'd60000000);
		rd(`STM_OFS_CWFREQ, q, e);
		chk("carrier ceiling", 32'd50000000, q);
		wr(ra(0, `STM_OFS_PERIOD), 32'(P));
		$display("test clamp done");
	endtask

	task automatic t_empty();
		stm_pkg::stm_samp_t a, b;
		wr(ra(0, `STM_OFS_CTRL), 32'h100);
		ctrl(0, 1, 0, 0);
		repeat (8) @(negedge clk);
		smp(0, a, b);
		chk("empty phase out", 32'h0, {8'h0, a, b});
		ctrl(0, 2, 0, 0);
		repeat (8) @(negedge clk);
		smp(0, a, b);
		chk("empty qam out", 32'h0, {8'h0, a, b});
		$display("test empty done");
	endtask

	task automatic t_types();
		logic [31:0] pe [11] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h2, 32'h4, 32'h40000,
			32'hf, 32'h0, 32'hf0, 32'hffb12300};
		int md [11] = '{1, 1, 1, 1, 1, 1, 1, 2, 2, 2, 2};
		int ty [11] = '{0, 1, 2, 3, 4, 5, 6, 0, 1, 2, 3};
		int ea [11] = '{-2047, 0, 0, 0, 0, 0, 0, 1536, -1792, 1920, 291};
		int eb [11] = '{0, 0, 0, 0, 2047, 2047, 2047, 1536, -1792, -1920, -5};
		stm_pkg::stm_samp_t a, b, a2, b2;
		for (int i = 0; i < 11; i++) begin
			wr(ra(0, `STM_OFS_CTRL), 32'h100);
			wr(ra(0, `STM_OFS_DATA), pe[i]);
			ctrl(0, md[i], ty[i], 0);
			repeat (8) @(negedge clk);
			smp(0, a, b);
			if (ty[i] == 3 && md[i] == 1) begin
				repeat (P) @(negedge clk);
				smp(0, a2, b2);
				chk("running phase", 32'h1, {31'h0, {a, b} !== {a2, b2}});
			end else if (md[i] == 1 && (ty[i] == 1 || ty[i] == 2)) begin
				if (ty[i] == 2) begin
					// Offset keying: Q follows half a symbol after I
					chk("offset q lags", 32'h0, 32'(b));
					repeat (P / 2) @(negedge clk);
					smp(0, a, b);
				end
				chk("45 deg point", 32'h1, {31'h0, a === b && a > 1000});
			end else begin
				chk("point i", 32'(ea[i]), 32'(a));
				chk("point q", 32'(eb[i]), 32'(b));
			end
		end
		smp(1, a, b);
		smp(1, a2, b2);
		chk("other pair runs", 32'h1, {31'h0, {a, b} !== {a2, b2}});
		chk("pair1 no sync", 32'h0, {16'h0, sync_cnt1});
		$display("test types done");
	endtask

	task automatic t_stream();
		logic [31:0] q;
		logic e;
		int n;
		stm_pkg::stm_samp_t a, b;
		wr(ra(0, `STM_OFS_CTRL), 32'h100);
		wr(ra(0, `STM_OFS_DATA), 32'h1);
		wr(ra(0, `STM_OFS_DATA), 32'h0);
		wr(ra(0, `STM_OFS_DATA), 32'h0);
		wr(ra(0, `STM_OFS_MARKER), 32'd9);
		rd(ra(0, `STM_OFS_STATUS), q, e);
		chk("len loaded", 32'd3, {23'h0, q[8:0]});
		ctrl(0, 1, 0, 0);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (sync_out[0] !== 1'b1 && n < 400);
		chk("sync found", 32'h1, {31'h0, n < 400});
		smp(0, a, b);
		chk("marker entry", 32'd2047, 32'(a));
		chk("carrier off q", 32'h0, 32'(b));
		repeat (P - 2) @(negedge clk);
		smp(0, a, b);
		chk("symbol holds", 32'd2047, 32'(a));
		smp(0, a, b);
		chk("wrap to first", 32'(-2047), 32'(a));
		repeat (2 * P - 2) @(negedge clk);
		chk("no early sync", 32'h0, {31'h0, sync_out[0]});
		@(negedge clk);
		chk("sync each pass", 32'h1, {31'h0, sync_out[0]});
		chk("stage saw sync", 32'h1, {31'h0, sync_cnt0 > 16'h0});
		$display("test stream done");
	endtask

	task automatic t_carrier();
		stm_pkg::stm_samp_t a [5];
		stm_pkg::stm_samp_t b [5];
		wr(`STM_OFS_CWFREQ, 32'd5000000);
		// Step size reaches the phase two clocks later, the output one more
		repeat (4) @(negedge clk);
		for (int i = 0; i < 5; i++) smp(1, a[i], b[i]);
		chk("quarter turn i", 32'h1, {31'h0, a[2] === -a[0] && a[4] === a[0]});
		chk("quarter turn q", 32'h1, {31'h0, b[2] === -b[0] && (a[0] | b[0]) !== 0});
		wr(ra(0, `STM_OFS_CTRL), 32'h100);
		wr(ra(0, `STM_OFS_DATA), 32'h0);
		ctrl(0, 1, 0, 1);
		repeat (8) @(negedge clk);
		for (int i = 0; i < 5; i++) smp(0, a[i], b[i]);
		chk("gated carrier", 32'h1,
			{31'h0, a[4] === a[0] && {a[1], b[1]} !== {a[0], b[0]}});
		ctrl(0, 1, 0, 0);
		repeat (8) @(negedge clk);
		smp(0, a[0], b[0]);
		chk("bare baseband", 32'h1, {31'h0, a[0] === 12'sd2047 && b[0] === 12'sd0});
		$display("test carrier done");
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_clamp();
		t_empty();
		t_types();
		t_stream();
		t_carrier();
		complete_run();
	end

	// Whole run is a few hundred cycles; this leaves ample margin
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		complete_run();
	end
endmodule
